// ### dv/davi_checker.sv
`timescale 1ns/1ps
module davi_checker
  import davi_pkg::*;
#(
  parameter int unsigned SAMPLE_DIV = SAMPLE_DIV_CYC
) (
  input wire logic          clk_i,
  input wire logic          rst_i,
  input wire davi_apb_req_s apb_i,
  input wire davi_sample_s  sample_i,
  input wire logic   [31:0] prdata_o,
  input wire logic          pready_o,
  input wire logic          pslverr_o,
  input wire logic          update_o
);
  // ----------------------------------------------------------------
  // result word decode
  // ----------------------------------------------------------------
  logic is_res;
  assign is_res = apb_i.paddr inside {10'h0B0, 10'h0B8, 10'h0C0, 10'h0C8, 10'h0D0, 10'h0D8};
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_rdy_pulse; pready_o |=> !pready_o; endproperty
  a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready longer than one cycle");
  property p_rdy_time; $rose(apb_i.penable) && apb_i.psel |-> ##1 pready_o; endproperty
  a_rdy_time: assert property (p_rdy_time) else $error("answer late");
  property p_rdy_cause; pready_o |-> apb_i.psel && apb_i.penable; endproperty
  a_rdy_cause: assert property (p_rdy_cause) else $error("answer without access");
  property p_err_rdy; pslverr_o |-> pready_o; endproperty
  a_err_rdy: assert property (p_err_rdy) else $error("error outside answer");
  property p_data_hold; !pready_o |-> $stable(prdata_o); endproperty
  a_data_hold: assert property (p_data_hold) else $error("read data moved");
  property p_res_word; pready_o && !apb_i.pwrite && is_res |-> prdata_o[31:16] == 16'h0000 && !pslverr_o; endproperty
  a_res_word: assert property (p_res_word) else $error("result word bad");
  property p_ro; pready_o && apb_i.pwrite && is_res |-> pslverr_o; endproperty
  a_ro: assert property (p_ro) else $error("result write taken");
  property p_unmap; pready_o && apb_i.paddr == 10'h3FC |-> pslverr_o && prdata_o == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read answered");
endmodule // davi_checker

bind davi_top davi_checker #(.SAMPLE_DIV(SAMPLE_DIV)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .apb_i(apb_i), .sample_i(sample_i), .prdata_o(prdata_o), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .update_o(update_o));

// ### dv/davi_top_tb_top.sv
`timescale 1ns/1ps
module davi_top_tb_top
  import davi_pkg::*;
;
  localparam int unsigned DIV = 20;
  localparam logic [7:0] RES[6] = '{8'h2C, 8'h2E, 8'h30, 8'h32, 8'h34, 8'h36};
  logic               clk_i = 1'b0;
  logic               rst_i = 1'b1;
  davi_apb_req_s      req = '0;
  davi_sample_s       smp = '0;
  logic        [31:0] prdata_o, rd;
  logic               pready_o, pslverr_o, update_o, er;
  logic signed [31:0] acc[3] = '{0, 0, 0};
  logic signed [31:0] prv[3] = '{0, 0, 0};
  int                 err_count = 0;
  int                 checks = 0;
  always #5 clk_i = ~clk_i;
  davi_top #(.SAMPLE_DIV(DIV)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .apb_i(req),
    .sample_i(smp), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .update_o(update_o));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] got, exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s exp=%h got=%h", nm, exp, got);
    end
  endtask
  task automatic report_and_stop;
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // waits for as long as the answer takes; only the hang guard ends a stuck transfer
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    @(posedge clk_i);
    req <= '{1'b1, 1'b0, wr, {idx, 2'b00}, wd};
    @(posedge clk_i);
    req.penable <= 1'b1;
    do begin
      @(posedge clk_i);
    end while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask
  task automatic wait_upd;
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (update_o !== 1'b1 && n < 400);
    chk("update_o", update_o, 32'h1);
  endtask
  task automatic send(input logic signed [15:0] z, x, y);
    @(posedge clk_i);
    smp <= {1'b1, z, x, y};
    @(posedge clk_i);
    smp.valid <= 1'b0;
    acc[0] += z + prv[0];
    acc[1] += x + prv[1];
    acc[2] += y + prv[2];
    prv = '{z, x, y};
  endtask
  task automatic chk_all;
    logic [31:0] lo;
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, RES[2*i], 32'h0);
      lo = rd;
      apb(1'b0, RES[2*i+1], 32'h0);
      chk("result_pair", {rd[15:0], lo[15:0]}, acc[i]);
    end
    acc = '{0, 0, 0};
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic s_reset;
    apb(1'b0, IDX_UPD_CNT, 32'h0);
    chk("upd_cnt", rd, 32'h0);
    apb(1'b0, IDX_CTRL, 32'h0);
    chk("ctrl", rd[0], CTRL_INT_CLK_RESET);
    apb(1'b0, IDX_DEC_SET, 32'h0);
    chk("dec", rd, {16'h0, DEC_SET_RESET});
    apb(1'b0, IDX_STATUS, 32'h0);
    chk("status", rd, 32'h0);
    apb(1'b0, 8'hFF, 32'h0);
    chk("unmapped_err", er, 32'h1);
  endtask
  task automatic s_ro;
    foreach (RES[i]) begin
      apb(1'b1, RES[i], 32'h0000_1234);
      chk("ro_err", er, 32'h1);
      apb(1'b0, RES[i], 32'h0);
      chk("ro_val", rd, 32'h0);
    end
  endtask
  task automatic s_span;
    int n;
    // update spacing at decimation 0 is what a reader measures to find the true rate
    wait_upd;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (update_o !== 1'b1 && n < 500);
    chk("rate_cycles", n, DIV);
    apb(1'b1, IDX_DEC_SET, 32'h0000_0002);
    wait_upd;
    wait_upd;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
      smp.valid <= (n == 1);
    end while (update_o !== 1'b1 && n < 500);
    chk("span_cycles", n, 3 * DIV);
    apb(1'b1, IDX_CTRL, 32'h0);
  endtask
  task automatic s_ext;
    logic [31:0] c0;
    apb(1'b0, IDX_UPD_CNT, 32'h0);
    c0 = rd;
    send(16'sd100, -16'sd5, 16'sd7000);
    send(16'sd200, -16'sd6, 16'sd8000);
    send(-16'sd300, -16'sd7, 16'sd9000);
    wait_upd;
    chk_all;
    repeat (3) send(16'sh7FFF, 16'sh8000, -16'sd1);
    wait_upd;
    chk_all;
    apb(1'b0, IDX_UPD_CNT, 32'h0);
    chk("upd_cnt", rd, c0 + 32'h2);
  endtask
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    s_reset;
    s_ro;
    s_span;
    s_ext;
    report_and_stop;
  end
  // hang guard, well beyond the few hundred cycles the run needs
  initial begin
    #100us;
    err_count++;
    report_and_stop;
  end
endmodule // davi_top_tb_top

// ### verilog/davi_pkg.sv
// Overview of operation
// - delta velocity sums adjacent sample pairs over the span, scaled by 1/(2*fs)
// - each span holds decimation_setting plus one samples
// - internal sample clock gives a nominal 2000 SPS integration rate
// - each axis result is one 32-bit two's-complement value in two words
// - z angle low word is read-only, holds the extra resolution bits
// - z angle high word is two's complement, LSB = 2160 deg / 2^15
// - z angle pair at 0x2C..0x2F, read-only, no default, no flash
// - 32-bit angle code 1 = 2160/2^31 deg, 0x80000000 = -2160 deg
// - x velocity high word two's complement, LSB = 400 m/s / 2^15
// - x velocity low word read-only, holds the extra resolution bits
// - x velocity pair at 0x30..0x33, low first, read-only
// - y velocity pair at 0x34..0x37, low first, same scale, read-only
// - delta angle uses the same trapezoid sum on angular rate samples
package davi_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS    = 10;
  localparam int unsigned SAMPLE_RATE_SPS  = 2000;
  localparam int unsigned SAMPLE_PERIOD_NS = 1_000_000_000 / SAMPLE_RATE_SPS;
  localparam int unsigned SAMPLE_DIV_CYC   = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // register map: printed offsets are indexes, byte address = 4 * index
  // ----------------------------------------------------------------
  localparam int ADDR_W = 10;
  localparam logic [7:0] IDX_Z_ANG_LOW  = 8'h2C;
  localparam logic [7:0] IDX_Z_ANG_HIGH = 8'h2E;
  localparam logic [7:0] IDX_X_VEL_LOW  = 8'h30;
  localparam logic [7:0] IDX_X_VEL_HIGH = 8'h32;
  localparam logic [7:0] IDX_Y_VEL_LOW  = 8'h34;
  localparam logic [7:0] IDX_Y_VEL_HIGH = 8'h36;
  localparam logic [7:0] IDX_DEC_SET    = 8'h50;
  localparam logic [7:0] IDX_CTRL       = 8'h51;
  localparam logic [7:0] IDX_STATUS     = 8'h52;
  localparam logic [7:0] IDX_UPD_CNT    = 8'h53;

  localparam int CTRL_INT_CLK_BIT = 0;
  localparam int STATUS_SAT_LSB   = 0;
  localparam logic [15:0] DEC_SET_RESET = 16'h0000;
  localparam logic        CTRL_INT_CLK_RESET = 1'b1;

  localparam int ACC_W  = 40;
  localparam int PROD_W = ACC_W + 16;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
  } davi_apb_req_s;

  typedef struct packed {
    logic        valid;
    logic [15:0] z_rate;
    logic [15:0] x_accel;
    logic [15:0] y_accel;
  } davi_sample_s;

  function automatic logic [ADDR_W-1:0] davi_addr(input logic [7:0] idx);
    davi_addr = {idx, 2'b00};
  endfunction

  // clamps the scaled sum into the 32-bit output code range
  function automatic logic [31:0] davi_sat32(input logic signed [PROD_W-1:0] v);
    if (v > $signed({{(PROD_W-32){1'b0}}, 32'h7FFFFFFF}))
      davi_sat32 = 32'h7FFFFFFF;
    else if (v < $signed({{(PROD_W-32){1'b1}}, 32'h80000000}))
      davi_sat32 = 32'h80000000;
    else
      davi_sat32 = v[31:0];
  endfunction

endpackage

// ### verilog/davi_top.sv
`timescale 1ns/1ps
module davi_top
  import davi_pkg::*;
#(
  parameter int unsigned SAMPLE_DIV = SAMPLE_DIV_CYC,
  parameter int          ANG_GAIN   = 1,
  parameter int          ANG_SHIFT  = 0,
  parameter int          VEL_GAIN   = 1,
  parameter int          VEL_SHIFT  = 0
) (
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  input  wire davi_apb_req_s apb_i,
  input  wire davi_sample_s  sample_i,
  output logic        [31:0] prdata_o,
  output logic               pready_o,
  output logic               pslverr_o,
  output logic               update_o
);

  localparam int TICK_W = $clog2(SAMPLE_DIV + 1);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(SAMPLE_DIV - 1);

  // ----------------------------------------------------------------
  // software state
  // ----------------------------------------------------------------
  logic [15:0] dec_set_r;
  logic        int_clk_r;
  logic [2:0]  sat_r;
  logic [15:0] upd_cnt_r;

  // ----------------------------------------------------------------
  // sample pacing
  // ----------------------------------------------------------------
  logic [TICK_W-1:0] tick_cnt_r;
  logic              tick;
  logic              take;

  assign tick = (tick_cnt_r == TICK_LAST);
  // internal clock picks up the sensor words every sample period
  assign take = int_clk_r ? tick : sample_i.valid;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tick_cnt_r <= '0;
    end else if (!int_clk_r || tick) begin
      tick_cnt_r <= '0;
    end else begin
      tick_cnt_r <= tick_cnt_r + TICK_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // decimation span
  // ----------------------------------------------------------------
  logic [15:0] span_cnt_r;
  logic [15:0] span_len_r;
  logic        span_end;

  // a new setting only takes hold at a span boundary, so no span is torn
  assign span_end = (span_cnt_r == span_len_r);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      span_cnt_r <= 16'h0000;
      span_len_r <= DEC_SET_RESET;
    end else if (take) begin
      if (span_end) begin
        span_cnt_r <= 16'h0000;
        span_len_r <= dec_set_r;
      end else begin
        span_cnt_r <= span_cnt_r + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      update_o  <= 1'b0;
      upd_cnt_r <= 16'h0000;
    end else begin
      update_o <= take && span_end;
      if (take && span_end) begin
        upd_cnt_r <= upd_cnt_r + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // integrators
  // ----------------------------------------------------------------
  logic [31:0] z_ang;
  logic [31:0] x_vel;
  logic [31:0] y_vel;
  logic [2:0]  sat_hit;

  davi_trap_integ #(
    .GAIN  (ANG_GAIN),
    .SHIFT (ANG_SHIFT)
  ) u_z_ang (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .take_i     (take),
    .span_end_i (span_end),
    .sample_i   (sample_i.z_rate),
    .result_o   (z_ang),
    .sat_o      (sat_hit[0])
  );

  davi_trap_integ #(
    .GAIN  (VEL_GAIN),
    .SHIFT (VEL_SHIFT)
  ) u_x_vel (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .take_i     (take),
    .span_end_i (span_end),
    .sample_i   (sample_i.x_accel),
    .result_o   (x_vel),
    .sat_o      (sat_hit[1])
  );

  davi_trap_integ #(
    .GAIN  (VEL_GAIN),
    .SHIFT (VEL_SHIFT)
  ) u_y_vel (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .take_i     (take),
    .span_end_i (span_end),
    .sample_i   (sample_i.y_accel),
    .result_o   (y_vel),
    .sat_o      (sat_hit[2])
  );

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic        access;
  logic        commit;
  logic [31:0] rd_data;
  logic        rd_ok;
  logic        wr_ok;

  assign access = apb_i.psel && apb_i.penable;
  assign commit = access && pready_o && apb_i.pwrite && wr_ok;

  always_comb begin
    rd_data = 32'h00000000;
    rd_ok   = 1'b1;
    wr_ok   = 1'b0;
    unique case (apb_i.paddr)
      davi_addr(IDX_Z_ANG_LOW): begin
        rd_data = {16'h0000, z_ang[15:0]};
      end
      davi_addr(IDX_Z_ANG_HIGH): begin
        rd_data = {16'h0000, z_ang[31:16]};
      end
      davi_addr(IDX_X_VEL_LOW): begin
        rd_data = {16'h0000, x_vel[15:0]};
      end
      davi_addr(IDX_X_VEL_HIGH): begin
        rd_data = {16'h0000, x_vel[31:16]};
      end
      davi_addr(IDX_Y_VEL_LOW): begin
        rd_data = {16'h0000, y_vel[15:0]};
      end
      davi_addr(IDX_Y_VEL_HIGH): begin
        rd_data = {16'h0000, y_vel[31:16]};
      end
      davi_addr(IDX_DEC_SET): begin
        rd_data = {16'h0000, dec_set_r};
        wr_ok   = 1'b1;
      end
      davi_addr(IDX_CTRL): begin
        rd_data = {31'h00000000, int_clk_r};
        wr_ok   = 1'b1;
      end
      davi_addr(IDX_STATUS): begin
        rd_data = {29'h00000000, sat_r};
        wr_ok   = 1'b1;
      end
      davi_addr(IDX_UPD_CNT): begin
        rd_data = {16'h0000, upd_cnt_r};
      end
      default: begin
        rd_ok = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // apb answer: one wait state, then pready for one cycle
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h00000000;
    end else if (access && !pready_o) begin
      pready_o  <= 1'b1;
      // result words are read-only: a write to them is answered with an error
      pslverr_o <= apb_i.pwrite ? !wr_ok : !rd_ok;
      prdata_o  <= apb_i.pwrite ? 32'h00000000 : rd_data;
    end else begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // writable registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      dec_set_r <= DEC_SET_RESET;
    end else if (commit && apb_i.paddr == davi_addr(IDX_DEC_SET)) begin
      dec_set_r <= apb_i.pwdata[15:0];
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      int_clk_r <= CTRL_INT_CLK_RESET;
    end else if (commit && apb_i.paddr == davi_addr(IDX_CTRL)) begin
      int_clk_r <= apb_i.pwdata[CTRL_INT_CLK_BIT];
    end
  end

  // sticky saturation flags, write one to clear; a new hit beats the clear
  logic [2:0] sat_clr;

  assign sat_clr = (commit && apb_i.paddr == davi_addr(IDX_STATUS)) ?
                   apb_i.pwdata[STATUS_SAT_LSB +: 3] : 3'h0;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sat_r <= 3'h0;
    end else begin
      sat_r <= (sat_r & ~sat_clr) | sat_hit;
    end
  end

endmodule // davi_top

// ### verilog/davi_trap_integ.sv
`timescale 1ns/1ps
module davi_trap_integ
  import davi_pkg::*;
#(
  parameter int GAIN  = 1,
  parameter int SHIFT = 0
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        take_i,
  input  wire logic        span_end_i,
  input  wire logic [15:0] sample_i,
  output logic      [31:0] result_o,
  output logic             sat_o
);

  // ----------------------------------------------------------------
  // trapezoid sum
  // ----------------------------------------------------------------
  logic signed [15:0]       prev_r;
  logic                     primed_r;
  logic signed [ACC_W-1:0]  acc_r;
  logic signed [16:0]       pair;
  logic signed [ACC_W-1:0]  acc_nxt;
  logic signed [PROD_W-1:0] scaled;
  logic signed [15:0]       gain_c;

  assign gain_c = 16'(GAIN);
  // first sample after reset pairs with itself, avoiding a step from zero
  assign pair = $signed({sample_i[15], sample_i}) +
                (primed_r ? $signed({prev_r[15], prev_r}) : $signed({sample_i[15], sample_i}));
  assign acc_nxt = acc_r + ACC_W'(pair);
  // gain and shift carry the 1/(2*fs) factor into the output code
  assign scaled = (PROD_W'(acc_nxt) * PROD_W'(gain_c)) >>> SHIFT;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prev_r   <= 16'sh0000;
      primed_r <= 1'b0;
    end else if (take_i) begin
      prev_r   <= sample_i;
      primed_r <= 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      acc_r <= '0;
    end else if (take_i) begin
      acc_r <= span_end_i ? '0 : acc_nxt;
    end
  end

  // ----------------------------------------------------------------
  // result, both halves from one register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      result_o <= 32'h00000000;
      sat_o    <= 1'b0;
    end else begin
      sat_o <= 1'b0;
      if (take_i && span_end_i) begin
        result_o <= davi_sat32(scaled);
        sat_o    <= (davi_sat32(scaled) != scaled[31:0]);
      end
    end
  end

endmodule // davi_trap_integ
